/* tcb_pkg.sv */
// package: register map, field layout and reset values of the transfer control block
package tcb_pkg;
  // ----------------------------------------------------------------------
  // register word offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_VECTOR_TABLE_BASE = 4'h0;
  localparam logic [3:0] OFS_TRANSFER_CONTROL = 4'h4;
  localparam logic [3:0] OFS_ADDRESS_MODE_SELECT = 4'h8;
  localparam logic [3:0] OFS_MODULE_START = 4'hc;
  localparam logic [3:0] OFS_TRANSFER_STATUS = 4'h0; // upper bank, see decode
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BASE_SIGN_BIT = 27;
  localparam int BASE_LOW_BITS = 10;
  localparam int BIT_READ_SKIP = 4;
  localparam int BIT_SHORT_MODE = 0;
  localparam int BIT_START = 0;
  localparam int BIT_ACTIVE = 15;
  localparam logic [17:0] RST_BASE_FIELD = 18'h00000;
  localparam logic RST_READ_SKIP = 1'b0;
  localparam logic RST_SHORT_MODE = 1'b0;
  localparam logic RST_START = 1'b0;
  // activation request from the interrupt controller
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } tcb_req_s;
  // order to the transfer engine
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic skip_info_read;
    logic short_mode;
    logic [31:0] table_base;
  } tcb_start_s;
endpackage

/* tcb_ctrl.sv */
// transfer controller base, control and status registers on an Avalon-MM slave
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - base top four bits sign-extend bit 27
// - base low ten bits read zero
// - same vector with skip set skips fetch
// - requests accepted only while started
// - active flag set on activation
// - active flag cleared when transfer done
// - monitor holds serviced vector number
module tcb_ctrl
  import tcb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire tcb_req_s req,
  output logic req_ready,
  output tcb_start_s start,
  input wire logic xfer_done
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } tcb_state_e;
  tcb_state_e state;
  logic [17:0] base_field; // bits 27..10 of the base
  logic read_skip;
  logic short_mode;
  logic module_start;
  logic active_flag;
  logic [7:0] active_vector_monitor;
  logic [7:0] last_vector;
  logic last_valid;
  logic acc_done;
  logic [31:0] base_full;
  logic take;
  logic next_module_start;
  // sign extension from bit 27, low ten bits always zero
  assign base_full = {{4{base_field[17]}}, base_field, {BASE_LOW_BITS{1'b0}}};
  // a request is taken only while started and no transfer runs
  assign take = req.valid && req_ready;
  // start bit as it stands after this edge; ready follows it at once, because a ready
  // lagging one cycle behind a stop write would let a request slip in while stopped
  assign next_module_start = (avs_write && acc_done && !avs_address[4] &&
    avs_address[3:0] == OFS_MODULE_START && avs_byteenable[0]) ?
    avs_writedata[BIT_START] : module_start;
  // ----------------------------------------------------------------------
  // bus slave: one wait cycle, answer at second edge
  // ----------------------------------------------------------------------
  // waitrequest drops for exactly one cycle per access, giving a two-cycle access
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_done <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      acc_done <= (avs_read || avs_write) && avs_waitrequest && !acc_done;
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !acc_done);
    end
  end
  // read data mux; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest && !acc_done) begin
      avs_readdata <= 32'h0000_0000;
      if (avs_address == ADDR_STATUS) begin
        avs_readdata[BIT_ACTIVE] <= active_flag;
        avs_readdata[7:0] <= active_vector_monitor;
      end else if (avs_address[4] == 1'b0) begin
        unique case (avs_address[3:0])
          OFS_VECTOR_TABLE_BASE: avs_readdata <= base_full;
          OFS_TRANSFER_CONTROL: avs_readdata[BIT_READ_SKIP] <= read_skip;
          OFS_ADDRESS_MODE_SELECT: avs_readdata[BIT_SHORT_MODE] <= short_mode;
          OFS_MODULE_START: avs_readdata[BIT_START] <= module_start;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------------
  // writable registers; status writes are dropped
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      base_field <= RST_BASE_FIELD;
      read_skip <= RST_READ_SKIP;
      short_mode <= RST_SHORT_MODE;
      module_start <= RST_START;
    end else if (avs_write && acc_done && !avs_address[4]) begin
      unique case (avs_address[3:0])
        OFS_VECTOR_TABLE_BASE: begin
          // bits 31..28 and 9..0 are discarded
          if (avs_byteenable[1]) base_field[5:0] <= avs_writedata[15:10];
          if (avs_byteenable[2]) base_field[13:6] <= avs_writedata[23:16];
          if (avs_byteenable[3]) base_field[17:14] <= avs_writedata[27:24];
        end
        OFS_TRANSFER_CONTROL: begin
          if (avs_byteenable[0]) read_skip <= avs_writedata[BIT_READ_SKIP];
        end
        OFS_ADDRESS_MODE_SELECT: begin
          if (avs_byteenable[0]) short_mode <= avs_writedata[BIT_SHORT_MODE];
        end
        OFS_MODULE_START: begin
          if (avs_byteenable[0]) module_start <= avs_writedata[BIT_START];
        end
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // activation and status tracking
  // ----------------------------------------------------------------------
  // the status fields change only by activation and completion, never by writes
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      active_flag <= 1'b0;
      active_vector_monitor <= 8'h00;
      req_ready <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          req_ready <= next_module_start;
          if (take) begin
            state <= ST_BUSY;
            active_flag <= 1'b1;
            active_vector_monitor <= req.vector;
            req_ready <= 1'b0;
          end
        end
        ST_BUSY: begin
          req_ready <= 1'b0;
          if (xfer_done) begin
            state <= ST_IDLE;
            active_flag <= 1'b0;
          end
        end
      endcase
    end
  end
  // start order to the engine, with skip decision on a repeated vector
  always_ff @(posedge clk) begin
    if (srst) begin
      start <= '0;
      last_vector <= 8'h00;
      last_valid <= 1'b0;
    end else begin
      start.valid <= take;
      if (take) begin
        start.vector <= req.vector;
        start.skip_info_read <= read_skip && last_valid && (last_vector == req.vector);
        start.short_mode <= short_mode;
        start.table_base <= base_full;
        last_vector <= req.vector;
        last_valid <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_base_sign_ext: assert property (@(posedge clk) disable iff (srst)
    base_full[31:28] == {4{base_full[27]}} && base_full[9:0] == 10'h000)
    else $error("base upper bits not sign extended or low bits set");
  chk_no_take_stop: assert property (@(posedge clk) disable iff (srst)
    !module_start && state == ST_IDLE |=> !start.valid)
    else $error("transfer started while module stopped");
  chk_active_set: assert property (@(posedge clk) disable iff (srst)
    take |=> active_flag && start.valid)
    else $error("active flag not set on activation");
  chk_active_clear: assert property (@(posedge clk) disable iff (srst)
    active_flag && xfer_done |=> !active_flag)
    else $error("active flag not cleared at completion");
  chk_monitor_hold: assert property (@(posedge clk) disable iff (srst)
    take |=> active_vector_monitor == $past(req.vector))
    else $error("monitor does not hold serviced vector");
  chk_skip_match: assert property (@(posedge clk) disable iff (srst)
    take && !read_skip |=> !start.skip_info_read)
    else $error("info read skipped while skip disabled");
  chk_status_ro: assert property (@(posedge clk) disable iff (srst)
    !take && !xfer_done |=> $stable(active_flag))
    else $error("active flag changed without cause");
  chk_short_pass: assert property (@(posedge clk) disable iff (srst)
    take |=> start.short_mode == $past(short_mode))
    else $error("address mode not passed to engine");
  chk_ready_started: assert property (@(posedge clk) disable iff (srst)
    req_ready |-> module_start)
    else $error("request ready while module stopped");
  chk_skip_repeat: assert property (@(posedge clk) disable iff (srst)
    take && read_skip && last_valid && last_vector == req.vector |=> start.skip_info_read)
    else $error("info read not skipped on repeated vector");
  chk_monitor_busy: assert property (@(posedge clk) disable iff (srst)
    state == ST_BUSY |=> $stable(active_vector_monitor))
    else $error("monitor changed during transfer");
  chk_flag_state: assert property (@(posedge clk) disable iff (srst)
    active_flag == (state == ST_BUSY))
    else $error("active flag disagrees with transfer state");
  chk_base_passed: assert property (@(posedge clk) disable iff (srst)
    take |=> start.table_base == $past(base_full))
    else $error("table base not passed to engine");
  // the answer must not stretch: a master seeing two low cycles would take a ghost access
  chk_wait_pulse: assert property (@(posedge clk) disable iff (srst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
endmodule

/* tcb_irq_model.sv */
// interrupt controller model raising one activation request at a time
`timescale 1ns/1ps
module tcb_irq_model
  import tcb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic send,
  input wire logic [7:0] send_vector,
  input wire logic req_ready,
  output tcb_req_s req
);
  // request held until taken; a released vector shows its inverse, never a stale copy
  always_ff @(posedge clk) begin
    if (srst) begin
      req <= '0;
    end else if (req.valid && req_ready) begin
      req.valid <= 1'b0;
      req.vector <= ~req.vector;
    end else if (send && !req.valid) begin
      req.valid <= 1'b1;
      req.vector <= send_vector;
    end
  end
endmodule

/* tb_top.sv */
// testbench for the transfer control block registers and activation path
`timescale 1ns/1ps
module tb_top;
  import tcb_pkg::*;
  logic clk, srst, avs_read, avs_write, avs_waitrequest, req_ready, send, xfer_done, short_en;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, wd, cur_base;
  logic [7:0] send_vector;
  tcb_req_s req;
  tcb_start_s start;
  int fail_count, compares, seed, last_vec, skip_en, n;

  tcb_ctrl u_tcb_ctrl (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req(req),
    .req_ready(req_ready), .start(start), .xfer_done(xfer_done));
  tcb_irq_model u_tcb_irq_model (.clk(clk), .srst(srst), .send(send),
    .send_vector(send_vector), .req_ready(req_ready), .req(req));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task end_of_test;
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one bus access; held until waitrequest is sampled low, bounded wait
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus_answer", n < 50, 1);
  endtask

  // one activation; stopped means the module is held off first, then started
  task xfer(input logic [7:0] v, input logic stopped);
    @(posedge clk);
    send <= 1'b1;
    send_vector <= v;
    @(posedge clk);
    send <= 1'b0;
    if (stopped) begin
      repeat (20) begin @(posedge clk); chk("stopped", {req_ready, start.valid}, 0); end
      bus(1, 5'h0c, 32'h1);
    end
    n = 0;
    do begin @(posedge clk); n++; end while (start.valid !== 1'b1 && n < 50);
    chk("start_valid", start.valid, 1);
    chk("start_vector", start.vector, v);
    chk("skip", start.skip_info_read, 32'(skip_en != 0 && last_vec == int'(v)));
    chk("short", start.short_mode, short_en);
    chk("table_base", start.table_base, cur_base);
    bus(1, ADDR_STATUS, 32'h0);
    bus(0, ADDR_STATUS, 32'h0);
    chk("status_busy", rd, {16'h0000, 1'b1, 7'h00, v});
    @(posedge clk) xfer_done <= 1'b1;
    @(posedge clk) xfer_done <= 1'b0;
    bus(0, ADDR_STATUS, 32'h0);
    chk("status_idle", rd[15], 0);
    last_vec = int'(v);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 84214;
    last_vec = -1;
    {fail_count, compares, skip_en, short_en, cur_base} = '0;
    {srst, avs_read, avs_write, avs_address, avs_writedata, send, send_vector} = '0;
    srst = 1'b1;
    xfer_done = 1'b0;
    avs_byteenable = 4'hf;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a <= 16; a += 4) begin bus(0, 5'(a), 0); chk("reset", rd, 0); end
    // boundary values first, then random ones; top nibble written is ignored
    for (int i = 0; i < 8; i++) begin
      wd = (i == 0) ? 32'hf7ff_fc00 : (i == 1) ? 32'h0800_0000 : $random(seed);
      wd[9:0] = 10'h000;
      bus(1, 5'h00, wd);
      cur_base = {{4{wd[27]}}, wd[27:10], 10'h000};
      bus(0, 5'h00, 0);
      chk("base", rd, cur_base);
    end
    bus(1, 5'h14, 32'hffff_ffff);
    bus(0, 5'h14, 0);
    chk("unmapped", rd, 0);
    bus(1, 5'h04, 32'h10);
    skip_en = 1;
    bus(1, 5'h08, 32'h1);
    short_en = 1'b1;
    xfer(8'h21, 1'b1);
    xfer(8'h21, 1'b0);
    xfer(8'h5a, 1'b0);
    bus(1, 5'h04, 32'h0);
    skip_en = 0;
    bus(1, 5'h08, 32'h0);
    short_en = 1'b0;
    xfer(8'h5a, 1'b0);
    repeat (3) xfer(8'($random(seed)), 1'b0);
    // stop again after running, then a held-off request must wait for the restart
    bus(1, 5'h0c, 32'h0);
    xfer(8'h3c, 1'b1);
    end_of_test();
  end

  // watchdog cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule
